// ===== dv/pin_partner.sv
// reset pin model: open-drain line with pull-up
`timescale 1ns/1ps
module pin_partner (
   input wire logic pull_low,
   input wire logic rst_pin_o,
   input wire logic rst_pin_oe,
   output logic pin_n
);
   // low when either party pulls, pull-up otherwise
   assign pin_n = ((rst_pin_oe && !rst_pin_o) || pull_low) ? 1'b0 : 1'b1;
endmodule : pin_partner

// ===== dv/sys_rst_monitor.sv
// assertion checker for the reset and clock controller
`timescale 1ns/1ps
module sys_rst_monitor #(
   parameter int PIN_POR_CYC = 4163
) (
   input wire logic clk,
   input wire logic resetn,
   input wire sys_ctrl_pkg::async_in_s async_in,
   input wire sys_ctrl_pkg::cpu_evt_s cpu_evt,
   input wire logic monitor_mode,
   input wire logic break_state,
   input wire logic [sys_ctrl_pkg::ADDR_W-1:0] addr,
   input wire logic [sys_ctrl_pkg::DATA_W-1:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [sys_ctrl_pkg::DATA_W-1:0] rd_data,
   input wire logic rst_pin_o,
   input wire logic rst_pin_oe,
   input wire logic internal_reset,
   input wire logic [sys_ctrl_pkg::ADDR_W-1:0] reset_vector,
   input wire logic periph_clk,
   input wire logic cpu_clk,
   input wire logic watchdog_disabled
);
   import sys_ctrl_pkg::*;
   logic [12:0] drv_cnt_r;
   logic [6:0] hold_cnt_r;
   logic drove_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // length of the current pin drive and of the hold after it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         drv_cnt_r <= '0;
         hold_cnt_r <= '0;
      end else begin
         drv_cnt_r <= rst_pin_oe ? drv_cnt_r + 13'h0001 : 13'h0000;
         hold_cnt_r <= (internal_reset && !rst_pin_oe) ? hold_cnt_r + 7'h01 : 7'h00;
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         drove_r <= 1'b1;
      end else if (rst_pin_oe) begin
         drove_r <= 1'b1;
      end else if (!internal_reset) begin
         drove_r <= 1'b0;
      end
   end
   property p_illegal_opcode_flag;
      cpu_evt.illegal_opcode && !internal_reset |=> rst_pin_oe && internal_reset;
   endproperty
   a_illegal_opcode_flag: assert property (p_illegal_opcode_flag) else $error("illegal opcode gave no reset");
   property p_halt;
      cpu_evt.halt_instr && !internal_reset |=> rst_pin_oe && internal_reset;
   endproperty
   a_halt: assert property (p_halt) else $error("halt gave no reset");
   property p_illad;
      cpu_evt.opcode_fetch && cpu_evt.fetch_unmapped && !internal_reset |=> rst_pin_oe && internal_reset;
   endproperty
   a_illad: assert property (p_illad) else $error("unmapped fetch gave no reset");
   property p_drv32;
      $fell(rst_pin_oe) |-> drv_cnt_r == 13'h0020 || drv_cnt_r >= 13'h1000;
   endproperty
   a_drv32: assert property (p_drv32) else $error("pin drive length wrong");
   property p_hold32;
      $fell(internal_reset) && drove_r |-> hold_cnt_r == 7'h20;
   endproperty
   a_hold32: assert property (p_hold32) else $error("reset hold length wrong");
   property p_vec;
      internal_reset |=> reset_vector == ($past(monitor_mode) ? VEC_MONITOR : VEC_USER);
   endproperty
   a_vec: assert property (p_vec) else $error("reset vector wrong");
   property p_clkoff;
      drv_cnt_r > 13'h0020 && drv_cnt_r < 13'h0FF0 |-> !periph_clk && !cpu_clk;
   endproperty
   a_clkoff: assert property (p_clkoff) else $error("clock ran in power count");
   property p_wdis;
      (monitor_mode && async_in.rst_hv) [*8] |-> watchdog_disabled;
   endproperty
   a_wdis: assert property (p_wdis) else $error("watchdog not disabled");
   property p_busdiv;
      $rose(periph_clk) |-> periph_clk [*2];
   endproperty
   a_busdiv: assert property (p_busdiv) else $error("bus clock high too short");
   c_illegal_opcode_flag: cover property (cpu_evt.illegal_opcode && !internal_reset);
   c_pin: cover property ($fell(internal_reset) && !drove_r);
   c_wdis: cover property ($rose(watchdog_disabled));
endmodule : sys_rst_monitor

bind system_reset_clock_control sys_rst_monitor #(.PIN_POR_CYC(PIN_POR_CYC)) sys_rst_monitor_inst (
   .clk(clk), .resetn(resetn), .async_in(async_in), .cpu_evt(cpu_evt), .monitor_mode(monitor_mode),
   .break_state(break_state), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
   .rd_data(rd_data), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .internal_reset(internal_reset),
   .reset_vector(reset_vector), .periph_clk(periph_clk), .cpu_clk(cpu_clk),
   .watchdog_disabled(watchdog_disabled));

// ===== dv/system_reset_clock_control_tb_top.sv
// testbench for the reset and clock controller
`timescale 1ns/1ps
module system_reset_clock_control_tb_top;
   import sys_ctrl_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic pin_low, wdog, uv, pll, rhv, ihv, monitor_mode, break_state, wr_stb, rd_stb;
   logic [1:0] pll_div = 2'b00;
   logic [15:0] addr;
   logic [7:0] wr_data;
   cpu_evt_s cpu_evt;
   async_in_s async_in;
   logic [7:0] rd_data;
   logic [15:0] reset_vector;
   logic rst_pin_o, rst_pin_oe, internal_reset, periph_clk, cpu_clk, watchdog_disabled, pin_n;
   int err_count = 0;
   int cmp_count = 0;
   assign async_in = '{rst_pin_n: pin_n, wdog_req: wdog, undervolt: uv, pll_clk: pll, rst_hv: rhv, irq_hv: ihv};
   system_reset_clock_control system_reset_clock_control_inst (
      .clk(clk), .resetn(resetn), .async_in(async_in), .cpu_evt(cpu_evt), .monitor_mode(monitor_mode),
      .break_state(break_state), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rd_data(rd_data), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .internal_reset(internal_reset),
      .reset_vector(reset_vector), .periph_clk(periph_clk), .cpu_clk(cpu_clk),
      .watchdog_disabled(watchdog_disabled));
   pin_partner pin_partner_inst (.pull_low(pin_low), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .pin_n(pin_n));
   initial begin
      forever #20 clk = ~clk;
   end
   // pll source at a quarter of the reference rate, slow enough for the input filter
   always @(posedge clk) pll_div <= pll_div + 2'b01;
   assign pll = pll_div[1];
   task print_verdict;
      if (err_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string nm);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 chk(nm, {8'h00, exp}, {8'h00, rd_data});
   endtask : rd
   task automatic ev(input cpu_evt_s v);
      @(posedge clk);
      cpu_evt <= v;
      @(posedge clk);
      cpu_evt <= '0;
   endtask : ev
   task automatic run_wait;
      int n;
      n = 0;
      while (internal_reset !== 1'b0 && n < 6000) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 6000) begin
         chk("run_timeout", 16'h0000, 16'h0001);
         print_verdict();
      end
   endtask : run_wait
   task automatic hi_len(output int n);
      n = 0;
      #1;
      while (rst_pin_oe === 1'b1 && n < 100) begin
         n++;
         @(posedge clk);
         #1;
      end
   endtask : hi_len
   task automatic edges(input int n, output int pe, output int ce);
      logic lp;
      logic lc;
      #1;
      pe = 0;
      ce = 0;
      lp = periph_clk;
      lc = cpu_clk;
      repeat (n) begin
         @(posedge clk);
         #1;
         if (periph_clk && !lp) pe++;
         if (cpu_clk && !lc) ce++;
         lp = periph_clk;
         lc = cpu_clk;
      end
   endtask : edges
   task automatic t_por;
      cyc(2000);
      chk("clk_held", 16'h0000, 16'(periph_clk | cpu_clk));
      cyc(2100);
      chk("ir_4100", 16'h0001, 16'(internal_reset));
      chk("oe_4100", 16'h0001, 16'(rst_pin_oe));
      run_wait();
      rd(REG_CAUSE_ADDR, CAUSE_RESET, "cause_por");
      rd(REG_CAUSE_ADDR, 8'h00, "cause_clr");
      rd(16'h0003, 8'h00, "unmapped");
   endtask : t_por
   task automatic t_src;
      logic [5:0] ev_v[3];
      logic [7:0] flag[4];
      int n;
      ev_v = '{6'h20, 6'h10, 6'h0C};
      flag = '{8'h08, 8'h08, 8'h10, 8'h04};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         monitor_mode <= i[0];
         if (i < 3) begin
            ev(cpu_evt_s'(ev_v[i]));
         end else begin
            wdog <= 1'b1;
            n = 0;
            while (rst_pin_oe !== 1'b1 && n < 20) begin
               @(posedge clk);
               #1;
               n++;
            end
            wdog <= 1'b0;
         end
         hi_len(n);
         chk("drive_len", 16'h0020, 16'(n));
         chk("vector", i[0] ? VEC_MONITOR : VEC_USER, reset_vector);
         run_wait();
         rd(REG_CAUSE_ADDR, flag[i], "cause_src");
      end
      @(posedge clk);
      monitor_mode <= 1'b0;
      ev(cpu_evt_s'(6'h04));
      cyc(8);
      chk("data_fetch", 16'h0000, 16'(internal_reset));
   endtask : t_src
   task automatic t_pin;
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         pin_low <= 1'b1;
         cyc(i ? 80 : 20);
         chk("pin_halt", 16'h0001, 16'(internal_reset));
         pin_low <= 1'b0;
         run_wait();
         rd(REG_CAUSE_ADDR, i ? 8'h02 : 8'h00, "cause_pin");
      end
   endtask : t_pin
   task automatic t_uv;
      @(posedge clk);
      uv <= 1'b1;
      cyc(10);
      chk("uv_oe", 16'h0001, 16'(rst_pin_oe));
      uv <= 1'b0;
      cyc(4000);
      chk("uv_ir", 16'h0001, 16'(internal_reset));
      run_wait();
      rd(REG_CAUSE_ADDR, 8'h20, "cause_uv");
   endtask : t_uv
   task automatic t_wd;
      cyc(8300);
      rd(REG_STATUS_ADDR, 8'h01, "wdog_count");
      wr(WDOG_SERVICE_ADDR, 8'hA5);
      rd(REG_STATUS_ADDR, 8'h00, "wdog_clear");
      cyc(8100);
      rd(REG_STATUS_ADDR, 8'h00, "presc_clear");
      cyc(150);
      rd(REG_STATUS_ADDR, 8'h01, "presc_period");
   endtask : t_wd
   task automatic t_wdis;
      @(posedge clk);
      monitor_mode <= 1'b1;
      rhv <= 1'b1;
      cyc(10);
      chk("wd_dis_rst", 16'h0001, 16'(watchdog_disabled));
      break_state <= 1'b1;
      rhv <= 1'b0;
      ihv <= 1'b1;
      cyc(10);
      chk("wd_dis_brk", 16'h0000, 16'(watchdog_disabled));
      break_state <= 1'b0;
      cyc(10);
      chk("wd_dis_irq", 16'h0001, 16'(watchdog_disabled));
      monitor_mode <= 1'b0;
      ihv <= 1'b0;
      cyc(10);
      chk("wd_en", 16'h0000, 16'(watchdog_disabled));
   endtask : t_wdis
   task automatic t_clk;
      int pe;
      int ce;
      edges(80, pe, ce);
      chk("osc_bus", 16'h0014, 16'(pe));
      wr(REG_CTRL_ADDR, 8'h01);
      rd(REG_CTRL_ADDR, 8'h01, "ctrl");
      cyc(16);
      edges(80, pe, ce);
      chk("pll_bus", 16'h0005, 16'(pe));
      wr(REG_CTRL_ADDR, 8'h00);
      cyc(16);
      ev(cpu_evt_s'(6'h02));
      edges(40, pe, ce);
      chk("wait_cpu", 16'h0000, 16'(ce));
      chk("wait_periph", 16'h000A, 16'(pe));
      ev(cpu_evt_s'(6'h01));
      cyc(8);
      edges(40, pe, ce);
      chk("wake_cpu", 16'h000A, 16'(ce));
   endtask : t_clk
   initial begin
      {pin_low, wdog, uv, rhv, ihv, monitor_mode, break_state, wr_stb, rd_stb} = '0;
      addr = '0;
      wr_data = '0;
      cpu_evt = '0;
      cyc(12);
      resetn <= 1'b1;
      t_por();
      t_src();
      t_pin();
      t_uv();
      t_wd();
      t_wdis();
      t_clk();
      print_verdict();
   end
endmodule : system_reset_clock_control_tb_top

// ===== rtl/sys_ctrl_pkg.sv
// constants, types and field layout for the system reset and clock controller
package sys_ctrl_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int PRESC_W = 13;
   localparam int WDOG_W = 6;
   localparam int CAUSE_W = 6;

   // register map on the plain register port
   localparam logic [ADDR_W-1:0] REG_CAUSE_ADDR = 16'h0000;
   localparam logic [ADDR_W-1:0] REG_CTRL_ADDR = 16'h0001;
   localparam logic [ADDR_W-1:0] REG_STATUS_ADDR = 16'h0002;
   localparam logic [ADDR_W-1:0] WDOG_SERVICE_ADDR = 16'hFFFF;

   // reset cause bit positions
   localparam int CAUSE_POR = 0;
   localparam int CAUSE_PIN = 1;
   localparam int CAUSE_WDOG = 2;
   localparam int CAUSE_ILLEGAL_OPCODE_FLAG = 3;
   localparam int CAUSE_ILLEGAL_ADDRESS_FLAG = 4;
   localparam int CAUSE_UV = 5;
   localparam logic [CAUSE_W-1:0] CAUSE_RESET = 6'h01;

   // control register
   localparam int CTRL_PLL_SEL = 0;
   localparam logic CTRL_PLL_SEL_RESET = 1'b0;

   // reset vectors
   localparam logic [ADDR_W-1:0] VEC_USER = 16'hFFFE;
   localparam logic [ADDR_W-1:0] VEC_MONITOR = 16'hFEFE;

   // sequencing counts, in oscillator reference cycles
   localparam logic [PRESC_W-1:0] POWER_CYC = 13'h1000;
   localparam logic [PRESC_W-1:0] DRIVE_CYC = 13'h0020;
   localparam logic [PRESC_W-1:0] HOLD_CYC = 13'h0020;
   localparam logic [PRESC_W-1:0] PIN_EXT_CYC = 13'h0043;
   localparam int PIN_POR_CYC_DEFAULT = 4163;
   localparam logic [PRESC_W-1:0] CNT_ONE = 13'h0001;
   localparam logic [PRESC_W-1:0] CNT_ZERO = 13'h0000;
   localparam logic [PRESC_W-1:0] CNT_MAX = 13'h1FFF;

   // prescaler bits kept by a watchdog service write (12..4 cleared)
   localparam logic [PRESC_W-1:0] PRESC_SERVICE_KEEP = 13'h000F;
   localparam logic [WDOG_W-1:0] WDOG_ZERO = 6'h00;
   localparam logic [WDOG_W-1:0] WDOG_ONE = 6'h01;
   localparam logic [WDOG_W-1:0] WDOG_MAX = 6'h3F;

   typedef enum logic [2:0] {
      ST_POWER,
      ST_PIN_DRIVE,
      ST_INTERNAL_RESET_HOLD,
      ST_EXT,
      ST_RUN
   } seq_e;

   // inputs from outside the clock domain
   typedef struct packed {
      logic rst_pin_n;
      logic wdog_req;
      logic undervolt;
      logic pll_clk;
      logic rst_hv;
      logic irq_hv;
   } async_in_s;

   localparam async_in_s ASYNC_IDLE = '{rst_pin_n: 1'b1, default: 1'b0};

   // same-clock event pulses from the cpu core
   typedef struct packed {
      logic illegal_opcode;
      logic halt_instr;
      logic opcode_fetch;
      logic fetch_unmapped;
      logic wait_instr;
      logic wake;
   } cpu_evt_s;

endpackage : sys_ctrl_pkg

// ===== rtl/system_reset_clock_control.sv
// reset sequencing, reset cause flags, watchdog prescaler and bus clock control
//
// Overview of operation
// R1 - bus clock is selected source divided by four
// R2 - bus clock is generator output divided by two
// R3 - power/undervoltage reset: clocks off 4096 cycles
// R4 - every source asserts internal reset and vector
// R5 - internal reset clears prescaler, pin reset not
// R6 - each source sets its own cause flag
// R7 - pin low halts; 67 cycles sets pin flag
// R8 - after power/undervoltage pin flag needs 4163 cycles
// R9 - internal source drives pin 32, holds 32 more
// R10 - power/undervoltage: pin low 4096, then normal sequence
// R11 - release CPU 64 cycles after power count
// R12 - power-on sets power flag, clears others
// R13 - watchdog overflow resets, sets watchdog flag
// R14 - write FFFF clears watchdog and prescaler 12-4
// R15 - prescaler overflow clocks the watchdog counter
// R16 - watchdog disabled only by high-voltage decode
// R17 - illegal instruction sets flag and resets
// R18 - halt instruction counts as illegal opcode
// R19 - wait mode stops cpu clock, peripherals run
// R20 - unmapped opcode fetch resets; data fetch not
// R21 - prescaler is 13 bits on reference clock
// R22 - undervoltage sets flag, follows power sequence
// R23 - synchronise pin and watchdog request inputs
`timescale 1ns/1ps

module system_reset_clock_control #(
   parameter int PIN_POR_CYC = sys_ctrl_pkg::PIN_POR_CYC_DEFAULT
) (
   input wire logic clk,
   input wire logic resetn,
   input wire sys_ctrl_pkg::async_in_s async_in,
   input wire sys_ctrl_pkg::cpu_evt_s cpu_evt,
   input wire logic monitor_mode,
   input wire logic break_state,
   input wire logic [sys_ctrl_pkg::ADDR_W-1:0] addr,
   input wire logic [sys_ctrl_pkg::DATA_W-1:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [sys_ctrl_pkg::DATA_W-1:0] rd_data,
   output logic rst_pin_o,
   output logic rst_pin_oe,
   output logic internal_reset,
   output logic [sys_ctrl_pkg::ADDR_W-1:0] reset_vector,
   output logic periph_clk,
   output logic cpu_clk,
   output logic watchdog_disabled
);
   import sys_ctrl_pkg::*;

   // three-stage input synchroniser with agreement filter
   logic [$bits(async_in_s)-1:0] sync1_r;
   logic [$bits(async_in_s)-1:0] sync2_r;
   logic [$bits(async_in_s)-1:0] sync3_r;
   logic [$bits(async_in_s)-1:0] filt_r;
   logic [$bits(async_in_s)-1:0] filt_nxt;
   async_in_s in_f;

   seq_e state_r;
   seq_e state_nxt;
   logic [PRESC_W-1:0] seq_cnt_r;
   logic [PRESC_W-1:0] seq_cnt_nxt;

   logic [PRESC_W-1:0] presc_r;
   logic [WDOG_W-1:0] wdog_r;
   logic [PRESC_W-1:0] pin_cnt_r;
   logic [PRESC_W-1:0] pin_thresh;
   logic por_seq_r;
   logic [CAUSE_W-1:0] cause_r;
   logic [CAUSE_W-1:0] cause_set;
   logic pll_sel_r;
   logic wait_r;

   logic pll_prev_r;
   logic gen_r;
   logic bus_phase_r;
   logic bus_phase_nxt;
   logic gen_tick;

   logic rd_data_r;
   logic [DATA_W-1:0] rd_word_r;
   logic rst_pin_o_r;
   logic rst_pin_oe_r;
   logic internal_reset_r;
   logic [ADDR_W-1:0] reset_vector_r;
   logic periph_clk_r;
   logic cpu_clk_r;
   logic wdog_dis_r;

   // decoded conditions of the current cycle
   logic running;
   logic clocks_on;
   logic pin_low;
   logic presc_tick;
   logic wdog_ovf;
   logic wdog_dis;
   logic wdog_fire;
   logic illegal_opcode_flag;
   logic illegal_address_flag;
   logic int_src;
   logic int_start;
   logic svc;
   logic cause_rd;
   logic pin_set;

   // counter helpers shared by the sequencer and the pin timer
   function automatic logic [PRESC_W-1:0] sat_inc(input logic [PRESC_W-1:0] v);
      sat_inc = (v == CNT_MAX) ? v : v + CNT_ONE;
   endfunction : sat_inc

   function automatic logic at_last(input logic [PRESC_W-1:0] cnt, input logic [PRESC_W-1:0] len);
      at_last = (cnt == len - CNT_ONE);
   endfunction : at_last

   // a bit only changes once stages two and three agree
   assign filt_nxt = (sync3_r & ~(sync2_r ^ sync3_r)) | (filt_r & (sync2_r ^ sync3_r));
   assign in_f = async_in_s'(filt_r);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync1_r <= ASYNC_IDLE;
         sync2_r <= ASYNC_IDLE;
         sync3_r <= ASYNC_IDLE;
         filt_r <= ASYNC_IDLE;
      end else begin
         sync1_r <= async_in; // [R23]
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         filt_r <= filt_nxt; // [R23]
      end
   end

   // running means internal reset is released
   assign running = (state_r == ST_RUN);
   assign clocks_on = (state_r != ST_POWER); // [R3]
   assign pin_low = ~in_f.rst_pin_n;
   assign svc = wr_stb && (addr == WDOG_SERVICE_ADDR);
   assign cause_rd = rd_stb && (addr == REG_CAUSE_ADDR);

   // watchdog disable: combinational high-voltage decode only
   assign wdog_dis = monitor_mode && (in_f.rst_hv || (in_f.irq_hv && !break_state)); // [R16]
   assign wdog_fire = !wdog_dis && (wdog_ovf || in_f.wdog_req); // [R13]
   assign illegal_opcode_flag = running && (cpu_evt.illegal_opcode || cpu_evt.halt_instr); // [R17] [R18]
   assign illegal_address_flag = running && cpu_evt.opcode_fetch && cpu_evt.fetch_unmapped; // [R20]
   assign int_src = running && (wdog_fire || illegal_opcode_flag || illegal_address_flag);

   // reset sequencer
   always_comb begin
      state_nxt = state_r;
      seq_cnt_nxt = seq_cnt_r + CNT_ONE;
      unique case (state_r)
         ST_POWER: begin
            if (at_last(seq_cnt_r, POWER_CYC)) begin // [R3] [R10]
               state_nxt = ST_PIN_DRIVE;
               seq_cnt_nxt = CNT_ZERO;
            end
         end
         ST_PIN_DRIVE: begin
            if (at_last(seq_cnt_r, DRIVE_CYC)) begin // [R9]
               state_nxt = ST_INTERNAL_RESET_HOLD;
               seq_cnt_nxt = CNT_ZERO;
            end
         end
         ST_INTERNAL_RESET_HOLD: begin
            if (at_last(seq_cnt_r, HOLD_CYC)) begin // [R9] [R11]
               state_nxt = ST_RUN;
               seq_cnt_nxt = CNT_ZERO;
            end
         end
         ST_EXT: begin
            // pin reset: wait for the pin to be released
            seq_cnt_nxt = CNT_ZERO;
            if (!pin_low) begin
               state_nxt = ST_INTERNAL_RESET_HOLD;
            end
         end
         ST_RUN: begin
            seq_cnt_nxt = CNT_ZERO;
            if (int_src) begin
               state_nxt = ST_PIN_DRIVE; // [R9]
            end else if (pin_low) begin
               state_nxt = ST_EXT; // [R7]
            end
         end
      endcase
      // undervoltage restarts the power count while it lasts
      if (in_f.undervolt) begin
         state_nxt = ST_POWER; // [R22]
         seq_cnt_nxt = CNT_ZERO;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_POWER;
         seq_cnt_r <= CNT_ZERO;
      end else begin
         state_r <= state_nxt;
         seq_cnt_r <= seq_cnt_nxt;
      end
   end

   // prescaler and watchdog
   assign int_start = in_f.undervolt || int_src;
   assign presc_tick = (presc_r == CNT_MAX);
   assign wdog_ovf = presc_tick && (wdog_r == WDOG_MAX);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         presc_r <= CNT_ZERO;
      end else if (int_start) begin
         presc_r <= CNT_ZERO; // [R5]
      end else if (svc) begin
         presc_r <= presc_r & PRESC_SERVICE_KEEP; // [R14]
      end else begin
         presc_r <= presc_r + CNT_ONE; // [R21]
      end
   end

   // watchdog count, cleared by any internal reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wdog_r <= WDOG_ZERO;
      end else if (internal_reset_r || svc) begin
         wdog_r <= WDOG_ZERO; // [R14] [R4]
      end else if (presc_tick) begin
         wdog_r <= wdog_r + WDOG_ONE; // [R15]
      end
   end

   // pin-low length measurement
   assign pin_thresh = por_seq_r ? PIN_POR_CYC[PRESC_W-1:0] : PIN_EXT_CYC; // [R8]
   assign pin_set = pin_low && at_last(pin_cnt_r, pin_thresh); // [R7]

   // saturates so a long pin hold cannot wrap
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pin_cnt_r <= CNT_ZERO;
      end else if (pin_low) begin
         pin_cnt_r <= sat_inc(pin_cnt_r);
      end else begin
         pin_cnt_r <= CNT_ZERO;
      end
   end

   // remembers a power-type sequence until the pin is released
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         por_seq_r <= 1'b1;
      end else if (state_nxt == ST_POWER) begin
         por_seq_r <= 1'b1; // [R8]
      end else if (running && !pin_low) begin
         por_seq_r <= 1'b0;
      end
   end

   // reset cause flags: read clears, a set in the same cycle wins
   always_comb begin
      cause_set = '0;
      cause_set[CAUSE_PIN] = pin_set; // [R6] [R7]
      cause_set[CAUSE_WDOG] = running && wdog_fire; // [R13]
      cause_set[CAUSE_ILLEGAL_OPCODE_FLAG] = illegal_opcode_flag; // [R17] [R18]
      cause_set[CAUSE_ILLEGAL_ADDRESS_FLAG] = illegal_address_flag; // [R20]
      cause_set[CAUSE_UV] = in_f.undervolt; // [R22]
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cause_r <= CAUSE_RESET; // [R12]
      end else begin
         cause_r <= (cause_r & ~{CAUSE_W{cause_rd}}) | cause_set; // [R6]
      end
   end

   // control register, returned to default by internal reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pll_sel_r <= CTRL_PLL_SEL_RESET;
      end else if (internal_reset_r) begin
         pll_sel_r <= CTRL_PLL_SEL_RESET; // [R4]
      end else if (wr_stb && (addr == REG_CTRL_ADDR)) begin
         pll_sel_r <= wr_data[CTRL_PLL_SEL];
      end
   end

   // wait mode, left on wake or on any reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wait_r <= 1'b0;
      end else if ((state_nxt != ST_RUN) || cpu_evt.wake) begin
         wait_r <= 1'b0;
      end else if (cpu_evt.wait_instr) begin
         wait_r <= 1'b1; // [R19]
      end
   end

   // clock derivation: source -> generator output (/2) -> bus (/2)
   assign gen_tick = pll_sel_r ? (in_f.pll_clk && !pll_prev_r) : 1'b1; // [R1]
   assign bus_phase_nxt = bus_phase_r ^ (gen_tick && !gen_r); // [R2]

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pll_prev_r <= 1'b0;
         gen_r <= 1'b0;
         bus_phase_r <= 1'b0;
      end else begin
         pll_prev_r <= in_f.pll_clk;
         gen_r <= gen_r ^ gen_tick; // [R1]
         bus_phase_r <= bus_phase_nxt; // [R2]
      end
   end

   // both clocks held low while the power count runs
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         periph_clk_r <= 1'b0;
         cpu_clk_r <= 1'b0;
      end else begin
         periph_clk_r <= clocks_on && bus_phase_nxt; // [R3] [R19]
         cpu_clk_r <= clocks_on && !wait_r && bus_phase_nxt; // [R19]
      end
   end

   // reset pin, internal reset and vector
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_pin_o_r <= 1'b0;
         rst_pin_oe_r <= 1'b1;
         internal_reset_r <= 1'b1;
         reset_vector_r <= VEC_USER;
         wdog_dis_r <= 1'b0;
      end else begin
         rst_pin_o_r <= 1'b0;
         rst_pin_oe_r <= (state_nxt == ST_POWER) || (state_nxt == ST_PIN_DRIVE); // [R9] [R10] [R3]
         internal_reset_r <= (state_nxt != ST_RUN); // [R4] [R7] [R11]
         if (state_nxt != ST_RUN) begin
            reset_vector_r <= monitor_mode ? VEC_MONITOR : VEC_USER; // [R4]
         end
         wdog_dis_r <= wdog_dis;
      end
   end

   // register read, data valid only in the cycle after the strobe
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_word_r <= '0;
         rd_data_r <= 1'b0;
      end else begin
         rd_data_r <= rd_stb;
         if (!rd_stb) begin
            rd_word_r <= '0;
         end else if (addr == REG_CAUSE_ADDR) begin
            rd_word_r <= {{(DATA_W-CAUSE_W){1'b0}}, cause_r};
         end else if (addr == REG_CTRL_ADDR) begin
            rd_word_r <= {{(DATA_W-1){1'b0}}, pll_sel_r};
         end else if (addr == REG_STATUS_ADDR) begin
            rd_word_r <= {wdog_dis_r, wait_r, wdog_r};
         end else begin
            rd_word_r <= '0;
         end
      end
   end

   // registered values driven straight to the ports
   assign rd_data = rd_word_r;
   assign rst_pin_o = rst_pin_o_r;
   assign rst_pin_oe = rst_pin_oe_r;
   assign internal_reset = internal_reset_r;
   assign reset_vector = reset_vector_r;
   assign periph_clk = periph_clk_r;
   assign cpu_clk = cpu_clk_r;
   assign watchdog_disabled = wdog_dis_r;

endmodule : system_reset_clock_control
